// >>> core/scp_pkg.sv
/*
  Shared constants and state types for the four-wire serial control port:
  frame layout, register map size, host timing and state encodings.
  Assumes a 25 MHz system clock shared by both ends.
*/
`default_nettype none

package scp_pkg;
  localparam int CLK_NS = 40;
  // Host-made serial clock half period; the host divides CLK down to it
  localparam int SCLK_HALF_NS = 320;
  localparam int HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 7;
  localparam int REG_NUM = 128;
  localparam int RW_BIT = 7;
  localparam int CSEL_BIT = 0;
  localparam int CHAIN_REG = 0;
  localparam int CHAIN_BIT = 7;
  localparam int MAX_CHAIN = 8;
  localparam int PLAIN_BITS = 16;
  localparam int CHAIN_BITS = 24;
  localparam logic [7:0] REG_RST = 8'h00;

  typedef enum logic [2:0]
  {
    D_IDLE = 3'b000,
    D_CSB = 3'b001,
    D_CMD = 3'b010,
    D_WR = 3'b011,
    D_RD = 3'b100,
    D_SKIP = 3'b101
  } scp_dst_t;

  typedef enum logic [2:0]
  {
    H_IDLE = 3'b000,
    H_SETUP = 3'b001,
    H_LOW = 3'b010,
    H_HIGH = 3'b011,
    H_END = 3'b100
  } scp_hst_t;
endpackage

`default_nettype wire

// >>> core/scp_if.sv
/*
  Link between host and device: select, clock, data both ways and the
  chain forward output. Resolves the data wires from the output enables.
  Assumes an undriven line floats high (pull-up).
*/
`timescale 1ns/1ps
`default_nettype none

interface scp_if #(parameter bit SHARED = 1'b0);
  logic sclk;
  logic cs_n;
  logic host_do;
  logic host_oe;
  logic dev_do;
  logic dev_oe;
  logic chain_fwd;
  logic sdi;
  logic miso;

  // With SHARED set, one wire carries both directions
  assign sdi = host_oe ? host_do : ((SHARED && dev_oe) ? dev_do : 1'b1);
  assign miso = dev_oe ? dev_do : ((SHARED && host_oe) ? host_do : 1'b1);

  modport dev (input sclk, input cs_n, input sdi, output dev_do, output dev_oe, output chain_fwd);
  modport host (output sclk, output cs_n, output host_do, output host_oe, input miso);
endinterface

`default_nettype wire

// >>> core/scp_sync.sv
/*
  Two-flop synchroniser for a group of pin inputs.
  Assumes each bit is an independent level; no bus coherence is given.
*/
`timescale 1ns/1ps
`default_nettype none

module scp_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_q <= RST_VAL;
      dout <= RST_VAL;
    end
    else if (ce)
    begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule // scp_sync

`default_nettype wire

// >>> core/scp_dev.sv
/*
  Device end of the serial control port: 128 byte registers reached by
  command/address plus data byte frames, optional three-byte chain mode.
  Assumes the serial clock is at least eight CLK periods long, so that
  every edge is seen after synchronisation.
*/
//
// Overview of operation
// - Access is command byte then data byte
// - Command MSB one reads, zero writes
// - Low seven command bits give register address
// - Read drives data byte out, MSB first
// - Release output after LSB fall or deselect
// - Input ignored during read data byte
// - Host sends write data MSB first
// - Output stays released throughout writes
// - Change on falling, sample on rising edges
// - Host parks serial clock high when idle
// - Host holds select low across whole byte
// - Shared wire needs host release on reads
// - Chain mode serves up to eight devices
// - Chain mode frames are three bytes
// - Select byte LSB selects this device
// - Forward select byte shifted right one
// - Command and data bytes forwarded unchanged
// - Forwarded select byte lags input one period
`timescale 1ns/1ps
`default_nettype none

module scp_dev (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  scp_if.dev LINK,
  output logic WR_STB,
  output logic [scp_pkg::ADDR_W-1:0] WR_ADDR,
  output logic [scp_pkg::BYTE_W-1:0] WR_DATA,
  output logic CHAIN_MODE
);
  import scp_pkg::*;

  scp_dst_t state_q;
  logic [2:0] sync_w;
  logic sclk_s;
  logic cs_n_s;
  logic sdi_s;
  logic sclk_prev_q;
  logic cs_prev_q;
  logic [2:0] bit_q;
  logic [BYTE_W-1:0] in_q;
  logic [ADDR_W-1:0] addr_q;
  logic [BYTE_W-1:0] out_q;
  logic [3:0] ocnt_q;
  logic rd_act_q;
  logic sdo_q;
  logic oe_q;
  logic fwd_q;
  logic [BYTE_W-1:0] mem [REG_NUM];

  // Clock, select and data arrive from the host's pins
  scp_sync #(
    .WIDTH(3),
    .RST_VAL(3'b111)
  ) u_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .ce(CE),
    .din({LINK.sclk, LINK.cs_n, LINK.sdi}),
    .dout(sync_w)
  );

  assign sclk_s = sync_w[2];
  assign cs_n_s = sync_w[1];
  assign sdi_s = sync_w[0];

  wire active_w = ~cs_n_s;
  wire frame_start_w = ~cs_n_s & cs_prev_q;
  wire sclk_rise_w = sclk_s & ~sclk_prev_q & active_w;
  wire sclk_fall_w = ~sclk_s & sclk_prev_q & active_w;
  wire byte_done_w = sclk_rise_w & (bit_q == 3'd7);
  wire [BYTE_W-1:0] in_next_w = {in_q[BYTE_W-2:0], sdi_s};
  wire cmd_done_w = byte_done_w & (state_q == D_CMD);
  wire is_read_w = in_next_w[RW_BIT];
  wire [ADDR_W-1:0] cmd_addr_w = in_next_w[ADDR_W-1:0];
  wire wr_fire_w = byte_done_w & (state_q == D_WR);
  wire chain_on_w = mem[CHAIN_REG][CHAIN_BIT];
  wire [BYTE_W-1:0] rd_byte_w = mem[cmd_addr_w];
  // Falls only, so leaving the select byte never moves the line mid-high
  wire fwd_bit_w = (state_q == D_CSB) ? in_q[0] : sdi_s;

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      sclk_prev_q <= 1'b1;
      cs_prev_q <= 1'b1;
    end
    else if (CE)
    begin
      sclk_prev_q <= sclk_s;
      cs_prev_q <= cs_n_s;
    end
  end

  // Frame sequencing; select high drops back to idle at once
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      state_q <= D_IDLE;
    else if (CE)
    begin
      if (!active_w)
        state_q <= D_IDLE;
      else if (frame_start_w)
        state_q <= chain_on_w ? D_CSB : D_CMD;
      else if (byte_done_w)
      begin
        case (state_q)
          D_CSB: state_q <= in_next_w[CSEL_BIT] ? D_CMD : D_SKIP;
          D_CMD: state_q <= is_read_w ? D_RD : D_WR;
          D_WR: state_q <= D_SKIP;
          D_RD: state_q <= D_SKIP;
          default: state_q <= state_q;
        endcase
      end
    end
  end

  // Bit counter and input shifter, sampled on rising edges only
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      bit_q <= 3'd0;
      in_q <= REG_RST;
    end
    else if (CE)
    begin
      if (!active_w || frame_start_w)
      begin
        bit_q <= 3'd0;
        in_q <= REG_RST;
      end
      else if (sclk_rise_w)
      begin
        bit_q <= bit_q + 3'd1;
        in_q <= in_next_w;
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      addr_q <= '0;
    else if (CE && cmd_done_w)
      addr_q <= cmd_addr_w;
  end

  // Read data: loaded at the end of the command byte, launched on falls
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      out_q <= REG_RST;
      ocnt_q <= 4'd0;
      rd_act_q <= 1'b0;
      sdo_q <= 1'b1;
      oe_q <= 1'b0;
    end
    else if (CE)
    begin
      if (!active_w)
      begin
        rd_act_q <= 1'b0;
        oe_q <= 1'b0;
      end
      else if (cmd_done_w && is_read_w)
      begin
        out_q <= rd_byte_w;
        ocnt_q <= 4'd0;
        rd_act_q <= 1'b1;
      end
      else if (sclk_fall_w && rd_act_q)
      begin
        if (ocnt_q == 4'(BYTE_W))
        begin
          rd_act_q <= 1'b0;
          oe_q <= 1'b0;
        end
        else
        begin
          sdo_q <= out_q[BYTE_W-1];
          out_q <= {out_q[BYTE_W-2:0], 1'b0};
          ocnt_q <= ocnt_q + 4'd1;
          oe_q <= 1'b1;
        end
      end
    end
  end

  // Chain forward: select byte delayed one period, others passed through
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      fwd_q <= 1'b0;
    else if (CE)
    begin
      if (!active_w || frame_start_w)
        fwd_q <= 1'b0;
      else if (sclk_fall_w)
        fwd_q <= fwd_bit_w;
    end
  end

  // Register array; a write lands only when the data byte completes
  for (genvar g = 0; g < REG_NUM; g++)
  begin : g_reg
    always_ff @(posedge CLK)
    begin
      if (!RST_N)
        mem[g] <= REG_RST;
      else if (CE && wr_fire_w && addr_q == ADDR_W'(g))
        mem[g] <= in_next_w;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      WR_STB <= 1'b0;
      WR_ADDR <= '0;
      WR_DATA <= REG_RST;
    end
    else if (CE)
    begin
      WR_STB <= wr_fire_w;
      if (wr_fire_w)
      begin
        WR_ADDR <= addr_q;
        WR_DATA <= in_next_w;
      end
    end
  end

  assign CHAIN_MODE = mem[CHAIN_REG][CHAIN_BIT];
  assign LINK.dev_do = sdo_q;
  assign LINK.dev_oe = oe_q;
  assign LINK.chain_fwd = fwd_q;
endmodule // scp_dev

`default_nettype wire

// >>> core/scp_host.sv
/*
  Host end of the serial control port: turns one request into a framed
  two- or three-byte access, making the serial clock by dividing CLK.
  Assumes the user knows whether the device has chain mode on.
*/
`timescale 1ns/1ps
`default_nettype none

module scp_host #(
  parameter int HALF = scp_pkg::HALF_CYC
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  scp_if.host LINK,
  input wire logic REQ,
  input wire logic REQ_READ,
  input wire logic [scp_pkg::ADDR_W-1:0] REQ_ADDR,
  input wire logic [scp_pkg::BYTE_W-1:0] REQ_WDATA,
  input wire logic [scp_pkg::BYTE_W-1:0] REQ_CSB,
  input wire logic CHAIN_MODE,
  output logic BUSY,
  output logic DONE,
  output logic [scp_pkg::BYTE_W-1:0] RD_DATA
);
  import scp_pkg::*;

  localparam int CW = $clog2(HALF) + 1;

  scp_hst_t state_q;
  logic [CW-1:0] cnt_q;
  logic [4:0] bit_q;
  logic [4:0] nbits_q;
  logic rd_q;
  logic [CHAIN_BITS-1:0] sh_q;
  logic [BYTE_W-1:0] rx_q;
  logic miso_s;
  logic sclk_q;
  logic cs_n_q;
  logic do_q;
  logic oe_q;

  scp_sync #(
    .WIDTH(1),
    .RST_VAL(1'b1)
  ) u_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .ce(CE),
    .din(LINK.miso),
    .dout(miso_s)
  );

  wire half_done_w = (cnt_q == CW'(HALF - 1));
  wire last_w = (bit_q == nbits_q - 5'd1);
  wire [4:0] next_b_w = (state_q == H_SETUP) ? 5'd0 : bit_q + 5'd1;
  wire rd_byte_w = rd_q && (next_b_w >= nbits_q - 5'(BYTE_W));
  wire take_w = (state_q == H_IDLE) && REQ;
  wire launch_w = half_done_w && ((state_q == H_SETUP) || (state_q == H_HIGH && !last_w));
  wire [4:0] req_bits_w = CHAIN_MODE ? 5'(CHAIN_BITS) : 5'(PLAIN_BITS);
  wire [BYTE_W-1:0] cmd_w = {REQ_READ, REQ_ADDR};
  wire [CHAIN_BITS-1:0] frame_w = CHAIN_MODE ? {REQ_CSB, cmd_w, REQ_WDATA} : {cmd_w, REQ_WDATA, 8'h00};

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      cnt_q <= '0;
    else if (CE)
      cnt_q <= (state_q == H_IDLE || half_done_w) ? '0 : cnt_q + CW'(1);
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      state_q <= H_IDLE;
    else if (CE)
    begin
      case (state_q)
        H_IDLE: if (REQ) state_q <= H_SETUP;
        H_SETUP: if (half_done_w) state_q <= H_LOW;
        H_LOW: if (half_done_w) state_q <= H_HIGH;
        H_HIGH: if (half_done_w) state_q <= last_w ? H_END : H_LOW;
        H_END: if (half_done_w) state_q <= H_IDLE;
        default: state_q <= H_IDLE;
      endcase
    end
  end

  // Frame setup and bit launch on each falling clock edge
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      bit_q <= 5'd0;
      nbits_q <= 5'(PLAIN_BITS);
      rd_q <= 1'b0;
      sh_q <= '0;
      do_q <= 1'b1;
      oe_q <= 1'b0;
    end
    else if (CE)
    begin
      if (take_w)
      begin
        bit_q <= 5'd0;
        nbits_q <= req_bits_w;
        rd_q <= REQ_READ;
        sh_q <= frame_w;
      end
      else if (launch_w)
      begin
        bit_q <= next_b_w;
        do_q <= sh_q[CHAIN_BITS-1];
        sh_q <= {sh_q[CHAIN_BITS-2:0], 1'b0};
        oe_q <= !rd_byte_w;
      end
      else if (state_q == H_END)
        oe_q <= 1'b0;
    end
  end

  // Clock falls at launch, rises half a period later; parks high
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      sclk_q <= 1'b1;
      cs_n_q <= 1'b1;
    end
    else if (CE)
    begin
      if (take_w)
        cs_n_q <= 1'b0;
      else if (launch_w)
        sclk_q <= 1'b0;
      else if (state_q == H_LOW && half_done_w)
        sclk_q <= 1'b1;
      else if (state_q == H_HIGH && half_done_w && last_w)
        cs_n_q <= 1'b1;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      rx_q <= '0;
      RD_DATA <= '0;
      DONE <= 1'b0;
      BUSY <= 1'b0;
    end
    else if (CE)
    begin
      if (state_q == H_LOW && half_done_w)
        rx_q <= {rx_q[BYTE_W-2:0], miso_s};
      DONE <= (state_q == H_END) && half_done_w;
      if ((state_q == H_END) && half_done_w && rd_q)
        RD_DATA <= rx_q;
      BUSY <= take_w || ((state_q != H_IDLE) && !((state_q == H_END) && half_done_w));
    end
  end

  assign LINK.sclk = sclk_q;
  assign LINK.cs_n = cs_n_q;
  assign LINK.host_do = do_q;
  assign LINK.host_oe = oe_q;
endmodule // scp_host

`default_nettype wire

// >>> test/scp_link_chk.sv
/*
  Checker on the link wires: select, clock, data enables, forward line.
  Assumes both ends on one scp_if and a serial half period of 8 CLK.
*/
`timescale 1ns/1ps
`default_nettype none

module scp_link_chk (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic host_do,
  input wire logic host_oe,
  input wire logic dev_do,
  input wire logic dev_oe,
  input wire logic chain_fwd
);
  logic [7:0] oe_cnt_q;
  logic [7:0] oe_cnt_d;

  // Length of the current read drive window
  assign oe_cnt_d = dev_oe ? oe_cnt_q + 8'h01 : 8'h00;

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      oe_cnt_q <= 8'h00;
    else
      oe_cnt_q <= oe_cnt_d;
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  a_oe_one_byte: assert property ($fell(dev_oe) |-> oe_cnt_q >= 8'h70 && oe_cnt_q <= 8'h88)
    else $error("read drive window is not one byte long");
  a_oe_max_len: assert property (oe_cnt_q <= 8'h88)
    else $error("read drive held past the byte");
  a_release_deselect: assert property (cs_n [*5] |-> !dev_oe)
    else $error("data output driven while deselected");
  a_oe_start: assert property ($rose(dev_oe) |-> !cs_n && !sclk)
    else $error("read drive started outside a low clock half");
  a_no_clash: assert property (!(dev_oe && host_oe))
    else $error("both ends drive data at once");
  a_sclk_park: assert property (cs_n |-> sclk)
    else $error("serial clock low while idle");
  a_select_fall: assert property ($fell(cs_n) |-> sclk)
    else $error("select fell with clock low");
  a_host_launch: assert property (host_oe && $past(host_oe) && $changed(host_do) |-> $fell(sclk))
    else $error("host data changed off a falling clock");
  a_dev_launch: assert property (dev_oe && $past(dev_oe) && $changed(dev_do) |-> !sclk)
    else $error("device data changed while clock high");
  a_fwd_launch: assert property (!cs_n && !$past(cs_n, 8) && $changed(chain_fwd) |-> !sclk)
    else $error("forward line changed while clock high");

  c_read: cover property ($rose(dev_oe));
  c_frame: cover property ($fell(cs_n));
  c_fwd_one: cover property (!cs_n && chain_fwd && !sclk);
endmodule // scp_link_chk

`default_nettype wire

// >>> test/spi_control_port_daisy_chain_bench.sv
/*
  Bench joining host and device ends: plain and chain frames, strobes,
  read data and the forward line are compared with expected values.
  Assumes separate data wires with a pull-up on the link.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin error_cnt++; \
  $display("ERROR at %0t: got %h exp %h", $time, (a), (e)); end end

module spi_control_port_daisy_chain_bench;
  import scp_pkg::*;
  localparam int TMO = 20000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req = 1'b0;
  logic req_read = 1'b0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [BYTE_W-1:0] req_wdata = '0;
  logic [BYTE_W-1:0] req_csb = '0;
  logic chain = 1'b0;
  logic busy;
  logic done;
  logic wr_stb;
  logic dev_chain;
  logic [ADDR_W-1:0] wr_addr;
  logic [BYTE_W-1:0] wr_data;
  logic [BYTE_W-1:0] rd_data;
  logic [23:0] fwd;
  int stb_n = 0;
  int cyc = 0;
  int error_cnt = 0;
  int tests_run = 0;

  scp_if #(.SHARED(1'b0)) u_scp_if ();

  scp_host #(.HALF(HALF_CYC)) u_scp_host (.CLK(clk), .RST_N(rst_n), .CE(1'b1), .LINK(u_scp_if.host),
    .REQ(req), .REQ_READ(req_read), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .REQ_CSB(req_csb),
    .CHAIN_MODE(chain), .BUSY(busy), .DONE(done), .RD_DATA(rd_data));

  scp_dev u_scp_dev (.CLK(clk), .RST_N(rst_n), .CE(1'b1), .LINK(u_scp_if.dev), .WR_STB(wr_stb),
    .WR_ADDR(wr_addr), .WR_DATA(wr_data), .CHAIN_MODE(dev_chain));

  scp_link_chk u_scp_link_chk (.CLK(clk), .RST_N(rst_n), .sclk(u_scp_if.sclk), .cs_n(u_scp_if.cs_n),
    .host_do(u_scp_if.host_do), .host_oe(u_scp_if.host_oe), .dev_do(u_scp_if.dev_do),
    .dev_oe(u_scp_if.dev_oe), .chain_fwd(u_scp_if.chain_fwd));

  initial
  begin
    forever #20 clk = ~clk;
  end

  // Forward line taken at each serial rise inside a frame
  always @(posedge u_scp_if.sclk)
  begin
    if (u_scp_if.cs_n === 1'b0)
      fwd = {fwd[22:0], u_scp_if.chain_fwd};
  end

  always @(posedge clk)
  begin
    if (wr_stb === 1'b1)
      stb_n <= stb_n + 1;
  end

  task automatic tally_and_finish();
    $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Stuck link must still reach the report
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == TMO)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic acc(input logic rd, input logic [6:0] ad, input logic [7:0] wd, input logic [7:0] cs);
    int n;
    n = 0;
    fwd = 24'h00_0000;
    @(negedge clk);
    req = 1'b1;
    req_read = rd;
    req_addr = ad;
    req_wdata = wd;
    req_csb = cs;
    @(negedge clk);
    req = 1'b0;
    `CHK(busy, 1'b1)
    while (done !== 1'b1 && n < 1000)
    begin
      @(negedge clk);
      n++;
    end
    `CHK(n < 1000, 1'b1)
    `CHK(busy, 1'b0)
  endtask

  task automatic wr(input logic [6:0] ad, input logic [7:0] wd, input logic [7:0] cs, input logic hit);
    int s;
    s = stb_n;
    acc(1'b0, ad, wd, cs);
    `CHK(stb_n - s, int'(hit))
    if (hit)
    begin
      `CHK(wr_addr, ad)
      `CHK(wr_data, wd)
    end
    if (chain)
      `CHK(fwd, {1'b0, cs[7:1], 1'b0, ad, wd})
  endtask

  task automatic rd(input logic [6:0] ad, input logic [7:0] cs, input logic [7:0] exp);
    acc(1'b1, ad, 8'h00, cs);
    `CHK(rd_data, exp)
  endtask

  initial
  begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    `CHK(dev_chain, 1'b0)
    rd(7'h00, 8'h00, 8'h00);
    wr(7'h05, 8'hA5, 8'h00, 1'b1);
    rd(7'h05, 8'h00, 8'hA5);
    wr(7'h7F, 8'h3C, 8'h00, 1'b1);
    rd(7'h7F, 8'h00, 8'h3C);
    rd(7'h05, 8'h00, 8'hA5);
    wr(7'h00, 8'h80, 8'h00, 1'b1);
    `CHK(dev_chain, 1'b1)
    chain = 1'b1;
    wr(7'h09, 8'h5A, 8'h03, 1'b1);
    rd(7'h09, 8'h01, 8'h5A);
    wr(7'h09, 8'h11, 8'hFE, 1'b0);
    rd(7'h09, 8'h01, 8'h5A);
    rd(7'h09, 8'h02, 8'hFF);
    wr(7'h00, 8'h00, 8'h01, 1'b1);
    chain = 1'b0;
    `CHK(dev_chain, 1'b0)
    rd(7'h09, 8'h00, 8'h5A);
    tally_and_finish();
  end
endmodule // spi_control_port_daisy_chain_bench

`undef CHK
`default_nettype wire
